// ---- verilog/fp_status_regs.svh ----
`ifndef FP_STATUS_REGS_SVH
`define FP_STATUS_REGS_SVH

// Status register field positions
`define FSTAT_CODE_LSB 0
`define FSTAT_CODE_MSB 2
`define FSTAT_UF_EN_BIT 3
`define FSTAT_UF_STICKY_BIT 4
`define FSTAT_IX_EN_BIT 5
`define FSTAT_IX_STICKY_BIT 6
`define FSTAT_RND_LSB 7
`define FSTAT_RND_MSB 8
`define FSTAT_SW_LSB 9
`define FSTAT_SW_MSB 15
`define FSTAT_MOD_BIT 16
// Writable / implemented bits
`define FSTAT_IMPL_MASK 32'h0001_FFFF
`define FSTAT_RESET 32'h0000_0000
// Register file reset value
`define FDATA_RESET 64'h0000_0000_0000_0000

`endif

// ---- verilog/fp_status_pkg.sv ----
package fp_status_pkg;

    typedef enum logic [2:0] {
        EXC_NONE = 3'h0,
        EXC_UNDERFLOW = 3'h1,
        EXC_OVERFLOW = 3'h2,
        EXC_DIV_ZERO = 3'h3,
        EXC_ILLEGAL = 3'h4,
        EXC_INVALID = 3'h5,
        EXC_INEXACT = 3'h6,
        EXC_RESERVED = 3'h7
    } exception_code_e;

    typedef enum logic [1:0] {
        RND_NEAREST = 2'h0,
        RND_TO_ZERO = 2'h1,
        RND_TO_POS = 2'h2,
        RND_TO_NEG = 2'h3
    } rounding_select_e;

    typedef enum logic [1:0] {
        INT_BYTE = 2'h0,
        INT_WORD = 2'h1,
        INT_DOUBLE = 2'h3
    } int_size_e;

    // Exception report from the datapath at instruction completion
    typedef struct packed {
        logic complete;
        logic underflow;
        logic overflow;
        logic div_by_zero;
        logic zero_by_zero;
        logic illegal;
        logic reserved_operand;
        logic inexact;
    } exc_report_s;

    // Register write port from the datapath
    typedef struct packed {
        logic en;
        logic double;
        logic [2:0] idx;
        logic [63:0] data;
    } reg_write_s;

    // Mode outputs toward the datapath
    typedef struct packed {
        rounding_select_e rounding_select;
        logic underflow_trap_enable;
        logic inexact_trap_enable;
    } mode_ctl_s;

endpackage : fp_status_pkg

// ---- verilog/fp_status_and_register_file.sv ----
`include "fp_status_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module fp_status_and_register_file
    import fp_status_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic load_status_instr_i,
    input wire logic [31:0] load_status_data_i,
    input wire logic store_status_instr_i,
    output logic [31:0] store_status_data_o,
    input wire exc_report_s exc_report_i,
    input wire reg_write_s reg_write_i,
    input wire logic [2:0] rd_idx_i,
    input wire logic rd_double_i,
    output logic [63:0] rd_data_o,
    output mode_ctl_s mode_ctl_o,
    output logic trap_request_o,
    output logic [31:0] fp_status_register_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Status fields

    logic [2:0] exception_code_reg;
    logic underflow_trap_enable_reg;
    logic inexact_trap_enable_reg;
    logic underflow_sticky_reg;
    logic inexact_sticky_reg;
    logic [1:0] rounding_select_reg;
    logic [6:0] software_field_reg;
    logic regs_modified_flag_reg;
    logic [2:0] exception_code_next;
    logic other_exc;
    logic [31:0] status_word;
    logic [63:0] fp_data_regs [0:7];

    // Priority encoding of the completion report; 111 never produced
    assign other_exc = exc_report_i.illegal | exc_report_i.reserved_operand | exc_report_i.zero_by_zero
        | exc_report_i.div_by_zero | exc_report_i.overflow | exc_report_i.underflow;

    always_comb
    begin
        if (exc_report_i.illegal)
            exception_code_next = EXC_ILLEGAL;
        else if (exc_report_i.reserved_operand || exc_report_i.zero_by_zero)
            exception_code_next = EXC_INVALID;
        else if (exc_report_i.div_by_zero)
            exception_code_next = EXC_DIV_ZERO;
        else if (exc_report_i.overflow)
            exception_code_next = EXC_OVERFLOW;
        else if (exc_report_i.underflow)
            exception_code_next = EXC_UNDERFLOW;
        else if (exc_report_i.inexact)
            exception_code_next = EXC_INEXACT;
        else
            exception_code_next = EXC_NONE;
    end

    // Code: load wins over completion; clean completion clears
    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            exception_code_reg <= 3'h0;
        else if (load_status_instr_i)
            exception_code_reg <= load_status_data_i[`FSTAT_CODE_MSB:`FSTAT_CODE_LSB];
        else if (exc_report_i.complete)
            exception_code_reg <= exception_code_next;
    end

    // Mode fields and software field
    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            underflow_trap_enable_reg <= 1'b0;
            inexact_trap_enable_reg <= 1'b0;
            rounding_select_reg <= 2'h0;
            software_field_reg <= 7'h00;
        end
        else if (load_status_instr_i)
        begin
            underflow_trap_enable_reg <= load_status_data_i[`FSTAT_UF_EN_BIT];
            inexact_trap_enable_reg <= load_status_data_i[`FSTAT_IX_EN_BIT];
            rounding_select_reg <= load_status_data_i[`FSTAT_RND_MSB:`FSTAT_RND_LSB];
            software_field_reg <= load_status_data_i[`FSTAT_SW_MSB:`FSTAT_SW_LSB];
        end
    end

    // Sticky flags: a hardware set wins over a load of zero
    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            underflow_sticky_reg <= 1'b0;
            inexact_sticky_reg <= 1'b0;
        end
        else
        begin
            if (exc_report_i.complete && exc_report_i.underflow)
                underflow_sticky_reg <= 1'b1;
            else if (load_status_instr_i)
                underflow_sticky_reg <= load_status_data_i[`FSTAT_UF_STICKY_BIT];
            if (exc_report_i.complete && exc_report_i.inexact && !other_exc)
                inexact_sticky_reg <= 1'b1;
            else if (load_status_instr_i)
                inexact_sticky_reg <= load_status_data_i[`FSTAT_IX_STICKY_BIT];
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            regs_modified_flag_reg <= 1'b0;
        else if (reg_write_i.en)
            regs_modified_flag_reg <= 1'b1;
        else if (load_status_instr_i)
            regs_modified_flag_reg <= load_status_data_i[`FSTAT_MOD_BIT];
    end

    // Trap request pulse; illegal and other errors cannot be disabled
    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            trap_request_o <= 1'b0;
        else
            trap_request_o <= exc_report_i.complete
                && ((exception_code_next != EXC_NONE && exception_code_next != EXC_UNDERFLOW
                     && exception_code_next != EXC_INEXACT)
                    || (exception_code_next == EXC_UNDERFLOW && underflow_trap_enable_reg)
                    || (exception_code_next == EXC_INEXACT && inexact_trap_enable_reg));
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status word

    always_comb
    begin
        status_word = `FSTAT_RESET;
        status_word[`FSTAT_CODE_MSB:`FSTAT_CODE_LSB] = exception_code_reg;
        status_word[`FSTAT_UF_EN_BIT] = underflow_trap_enable_reg;
        status_word[`FSTAT_UF_STICKY_BIT] = underflow_sticky_reg;
        status_word[`FSTAT_IX_EN_BIT] = inexact_trap_enable_reg;
        status_word[`FSTAT_IX_STICKY_BIT] = inexact_sticky_reg;
        status_word[`FSTAT_RND_MSB:`FSTAT_RND_LSB] = rounding_select_reg;
        status_word[`FSTAT_SW_MSB:`FSTAT_SW_LSB] = software_field_reg;
        status_word[`FSTAT_MOD_BIT] = regs_modified_flag_reg;
    end

    assign fp_status_register_o = status_word;

    // Store-status captures the whole word in one 32-bit transfer
    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            store_status_data_o <= 32'h0000_0000;
        else if (store_status_instr_i)
            store_status_data_o <= status_word & `FSTAT_IMPL_MASK;
    end

    assign mode_ctl_o.rounding_select = rounding_select_e'(rounding_select_reg);
    assign mode_ctl_o.underflow_trap_enable = underflow_trap_enable_reg;
    assign mode_ctl_o.inexact_trap_enable = inexact_trap_enable_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Data registers; half-width view: even index low half, next index high

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_reg
            always_ff @(posedge sys_clk_i or negedge rst_b_i)
            begin
                if (!rst_b_i)
                    fp_data_regs[gi] <= `FDATA_RESET;
                else if (reg_write_i.en && reg_write_i.idx == 3'(gi))
                    fp_data_regs[gi] <= reg_write_i.double
                        ? reg_write_i.data : {fp_data_regs[gi][63:32], reg_write_i.data[31:0]};
                else if (reg_write_i.en && reg_write_i.double && !reg_write_i.idx[0]
                         && reg_write_i.idx == 3'(gi - 1))
                    fp_data_regs[gi] <= {fp_data_regs[gi][63:32], reg_write_i.data[63:32]};
            end
        end
    endgenerate

    // Read: double from an even index joins the pair, low half first
    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            rd_data_o <= `FDATA_RESET;
        else if (rd_double_i && !rd_idx_i[0])
            rd_data_o <= {fp_data_regs[rd_idx_i + 3'h1][31:0], fp_data_regs[rd_idx_i][31:0]};
        else
            rd_data_o <= fp_data_regs[rd_idx_i];
    end

endmodule : fp_status_and_register_file

`default_nettype wire

// ---- verif/fp_status_monitor.sv ----
`include "fp_status_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module fp_status_monitor
    import fp_status_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic load_status_instr_i,
    input wire logic [31:0] load_status_data_i,
    input wire logic store_status_instr_i,
    input wire logic [31:0] store_status_data_o,
    input wire exc_report_s exc_report_i,
    input wire reg_write_s reg_write_i,
    input wire logic [2:0] rd_idx_i,
    input wire logic rd_double_i,
    input wire logic [63:0] rd_data_o,
    input wire mode_ctl_s mode_ctl_o,
    input wire logic trap_request_o,
    input wire logic [31:0] fp_status_register_o
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_b_i);
    logic [31:0] st;
    logic done;
    logic err;
    assign st = fp_status_register_o;
    assign done = exc_report_i.complete && !load_status_instr_i;
    assign err = |exc_report_i[6:1];
    sequence illegal_done;
        done && exc_report_i.illegal ##1 !exc_report_i.complete;
    endsequence
    sequence trap_pulse;
        st[2:0] == 3'h4 && trap_request_o ##1 !trap_request_o;
    endsequence
    AST_LOAD: assert property (load_status_instr_i && !exc_report_i.complete && !reg_write_i.en
        |=> st == ($past(load_status_data_i) & `FSTAT_IMPL_MASK)) else $error("status load wrong");
    AST_STORE: assert property (store_status_instr_i |=> store_status_data_o == $past(st))
        else $error("stored word wrong");
    AST_MODE: assert property (mode_ctl_o == {st[8:7], st[3], st[5]})
        else $error("mode outputs wrong");
    AST_NO_111: assert property (st[2:0] != 3'h7)
        else $error("reserved code seen");
    AST_CLEAN: assert property (done && !exc_report_i[6:0] |=> st[2:0] == 3'h0)
        else $error("code not cleared");
    AST_UF: assert property (done && exc_report_i.underflow |=> st[4] && st[2:0] != 3'h0)
        else $error("underflow not recorded");
    AST_MOD: assert property (reg_write_i.en |=> st[16])
        else $error("modify flag not set");
    AST_STICKY: assert property ($fell(st[4]) || $fell(st[6]) |-> $past(load_status_instr_i))
        else $error("sticky flag lost");
    AST_ILLEGAL: assert property (illegal_done |-> trap_pulse)
        else $error("illegal code or trap wrong");
    AST_INEXACT: assert property (done && exc_report_i.inexact && !err |=> st[2:0] == 3'h6 && st[6])
        else $error("inexact not recorded");
endmodule : fp_status_monitor

bind fp_status_and_register_file fp_status_monitor mon (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
    .load_status_instr_i(load_status_instr_i), .load_status_data_i(load_status_data_i),
    .store_status_instr_i(store_status_instr_i), .store_status_data_o(store_status_data_o),
    .exc_report_i(exc_report_i), .reg_write_i(reg_write_i), .rd_idx_i(rd_idx_i), .rd_double_i(rd_double_i),
    .rd_data_o(rd_data_o), .mode_ctl_o(mode_ctl_o), .trap_request_o(trap_request_o),
    .fp_status_register_o(fp_status_register_o));

`default_nettype wire

// ---- verif/host_cpu_model.sv ----
`timescale 1ns/100ps
`default_nettype none

module host_cpu_model (
    input wire logic sys_clk_i,
    output logic load_o,
    output logic [31:0] load_data_o,
    output logic store_o
);
    initial
    begin
        load_o = 1'b0;
        load_data_o = 32'h0000_0000;
        store_o = 1'b0;
    end
    // Whole word per transfer; data scrambled once released
    task automatic load_word(input logic [31:0] w);
        load_o = 1'b1;
        load_data_o = w;
        @(posedge sys_clk_i);
        #1;
        load_o = 1'b0;
        load_data_o = ~w;
        @(posedge sys_clk_i);
        #1;
    endtask : load_word
    task automatic store_word();
        store_o = 1'b1;
        @(posedge sys_clk_i);
        #1;
        store_o = 1'b0;
        @(posedge sys_clk_i);
        #1;
    endtask : store_word
endmodule : host_cpu_model

`default_nettype wire

// ---- verif/fp_status_and_register_file_test.sv ----
`timescale 1ns/100ps
`default_nettype none

module fp_status_and_register_file_test
    import fp_status_pkg::*;
;
    logic sys_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic ld, st;
    logic [31:0] ld_data, st_data, status;
    exc_report_s exc = '0;
    reg_write_s wr = '0;
    logic [2:0] rd_idx = 3'h0;
    logic rd_double = 1'b0;
    logic [63:0] rd_data;
    mode_ctl_s mode;
    logic trap;
    int num_errors = 0;
    int n_checks = 0;
    logic [6:0] flags [8] = '{7'h21, 7'h01, 7'h40, 7'h10, 7'h08, 7'h02, 7'h06, 7'h00};
    logic [2:0] codes [8] = '{3'h2, 3'h6, 3'h1, 3'h3, 3'h5, 3'h5, 3'h4, 3'h0};
    logic uf, ix, ue, ie;

    always #2.5 sys_clk_i = ~sys_clk_i;

    host_cpu_model host (.sys_clk_i(sys_clk_i), .load_o(ld), .load_data_o(ld_data), .store_o(st));
    fp_status_and_register_file dut (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .load_status_instr_i(ld),
        .load_status_data_i(ld_data), .store_status_instr_i(st), .store_status_data_o(st_data),
        .exc_report_i(exc), .reg_write_i(wr), .rd_idx_i(rd_idx), .rd_double_i(rd_double),
        .rd_data_o(rd_data), .mode_ctl_o(mode), .trap_request_o(trap), .fp_status_register_o(status));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic step();
        @(posedge sys_clk_i);
        #1;
    endtask : step
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic complete_run();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : complete_run

    initial
    begin
        #100000;
        num_errors++;
        complete_run();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20) step();
        rst_b_i = 1'b1;
        chk(status, 64'h0);
        host.load_word(32'hFFFF_FFFE);
        chk(status, 64'h0001_FFFE);
        host.store_word();
        chk(st_data, 64'h0001_FFFE);
        for (int r = 0; r < 4; r++)
        begin
            host.load_word(32'(r) << 7);
            chk(mode, 64'(r) << 2);
        end
        for (int m = 0; m < 2; m++)
        begin
            ue = (m == 0);
            ie = (m == 1);
            uf = 1'b0;
            ix = 1'b0;
            host.load_word({26'h0, ie, 1'b0, ue, 3'h0});
            chk(mode, {2'h0, ue, ie});
            for (int k = 0; k < 8; k++)
            begin
                exc = {1'b1, flags[k]};
                step();
                exc = '0;
                uf |= flags[k][6];
                ix |= (flags[k] == 7'h01);
                chk(status, {25'h0, ix, ie, uf, ue, codes[k]});
                chk(trap, (codes[k] inside {3'h2, 3'h3, 3'h4, 3'h5}) || (codes[k] == 3'h1 && ue)
                    || (codes[k] == 3'h6 && ie));
                step();
            end
        end
        host.load_word(32'h0000_0000);
        chk(status, 64'h0);
        wr = {1'b1, 1'b1, 3'h2, 64'h89AB_CDEF_0123_4567};
        step();
        wr = {1'b1, 1'b0, 3'h5, 64'hFEDC_BA98_7654_3210};
        chk(status, 64'h0001_0000);
        step();
        wr = '0;
        rd_idx = 3'h2;
        rd_double = 1'b1;
        step();
        chk(rd_data, 64'h89AB_CDEF_0123_4567);
        rd_idx = 3'h3;
        rd_double = 1'b0;
        step();
        chk(rd_data, 64'h0000_0000_89AB_CDEF);
        rd_idx = 3'h5;
        step();
        chk(rd_data, 64'h0000_0000_7654_3210);
        host.load_word(32'h0000_0000);
        chk(status, 64'h0);
        host.load_word(32'h0001_0050);
        rst_b_i = 1'b0;
        step();
        chk(status, 64'h0);
        rst_b_i = 1'b1;
        step();
        complete_run();
    end
endmodule : fp_status_and_register_file_test

`default_nettype wire
